// >>> shared/cwbs_regs.svh
/*
  timing-free constants for the write buffer slice: widths, depth, pointer sizes.
  assumes it is included by bare name from the package and design files.
*/
`ifndef CWBS_REGS_SVH
`define CWBS_REGS_SVH
`define CWBS_DEPTH      4
`define CWBS_PTR_W      2
`define CWBS_CNT_W      3
`define CWBS_ADDR_W     8
`define CWBS_ADLO_LSB   0
`define CWBS_ADLO_MSB   3
`define CWBS_ADHI_LSB   4
`define CWBS_ADHI_MSB   7
`define CWBS_DATA_W     9
`define CWBS_BPTR_W     2
`define CWBS_ACC_W      2
`define CWBS_CNT_ZERO   3'h0
`define CWBS_CNT_ONE    3'h1
`define CWBS_CNT_FULL   3'h4
`define CWBS_CNT_LAST   3'h3
`define CWBS_CNT_TWO    3'h2
`define CWBS_PTR_ONE    2'h1
`endif

// >>> shared/cwbs_pkg.sv
/*
  types shared by the write buffer slice modules.
  assumes cwbs_regs.svh is on the include path.
*/
`include "cwbs_regs.svh"
package cwbs_pkg;
  typedef logic [`CWBS_ADDR_W-1:0] cwbs_addr_t;
  typedef logic [`CWBS_DATA_W-1:0] cwbs_data_t;
  typedef logic [`CWBS_BPTR_W-1:0] cwbs_bptr_t;
  typedef logic [`CWBS_ACC_W-1:0]  cwbs_acc_t;
  typedef logic [`CWBS_PTR_W-1:0]  cwbs_ptr_t;
  typedef logic [`CWBS_CNT_W-1:0]  cwbs_cnt_t;
  typedef struct packed {
    cwbs_addr_t addr;
    cwbs_bptr_t bptr;
    cwbs_acc_t  acc;
    cwbs_data_t data;
  } cwbs_entry_t;
endpackage : cwbs_pkg

// >>> shared/cwbs_cap_if.sv
/*
  carries a captured store entry from the capture stage to the storage array.
  assumes both ends share clk.
*/
`timescale 1ns/1ps
interface cwbs_cap_if;
  import cwbs_pkg::*;
  logic        push;
  cwbs_entry_t entry;
  modport src (output push, output entry);
  modport dst (input push, input entry);
endinterface : cwbs_cap_if

// >>> design/cwbs_capture.sv
/*
  capture stage: gathers one store entry, low address half and byte pointer
  from the falling edge, the rest from the rising edge.
  assumes processor inputs are synchronous to clk, as the processor times them.
*/
`timescale 1ns/1ps
`include "cwbs_regs.svh"
module cwbs_capture
  import cwbs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       store_strobe,
  input  wire cwbs_addr_t addr_in,
  input  wire cwbs_bptr_t bptr_in,
  input  wire cwbs_acc_t  access_size_code,
  input  wire cwbs_data_t data_in,
  cwbs_cap_if.src         cap
);
  logic [`CWBS_ADLO_MSB:`CWBS_ADLO_LSB] adlo_q;
  logic [`CWBS_ADLO_MSB:`CWBS_ADLO_LSB] adlo_d;
  cwbs_bptr_t                           bptr_q;
  cwbs_bptr_t                           bptr_d;
  cwbs_entry_t                          ent_d;
  cwbs_entry_t                          ent_q;
  logic                                 push_d;
  logic                                 push_q;

  // trailing half: only the adlo and byte pointer buses are stable then
  always_comb begin
    adlo_d = adlo_q;
    bptr_d = bptr_q;
    if (store_strobe) begin
      adlo_d = addr_in[`CWBS_ADLO_MSB:`CWBS_ADLO_LSB];
      bptr_d = bptr_in;
    end
  end

  always_ff @(negedge clk) begin
    adlo_q <= adlo_d;
    bptr_q <= bptr_d;
  end

  always_comb begin
    push_d     = store_strobe;
    ent_d      = ent_q;
    if (store_strobe) begin
      ent_d.addr = {addr_in[`CWBS_ADHI_MSB:`CWBS_ADHI_LSB], adlo_q};
      ent_d.bptr = bptr_q;
      ent_d.acc  = access_size_code;
      ent_d.data = data_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      push_q <= 1'b0;
      ent_q  <= '0;
    end else begin
      push_q <= push_d;
      ent_q  <= ent_d;
    end
  end

  assign cap.push  = push_q;
  assign cap.entry = ent_q;
endmodule : cwbs_capture

// >>> design/cwbs_slice.sv
/*
  one slice of the processor write buffer: four entries, full flag, and
  request / output-enable / acknowledge drain to a memory controller.
  assumes clk is the processor's inverted system clock and that the memory
  controller meets setup and hold of acknowledge to clk.
*/
// What this block does
// - four entries of 8-bit address, 9-bit data
// - four slices give 32 address, 36 data
// - each store captures data, address, size code
// - hold up to four pending entries
// - one synchronous capture per clock cycle
// - flag full while room remains for a store in flight
// - handshake with memory controller to drain
// - adlo and tag bits form the address
// - entries carry data, parity, access type bits
// - accept stores during run cycles
// - full when three held, or two held and a store strobed
// - low address and byte pointer on trailing edge, rest rising
// - oe drives oldest, acknowledge discards it
// - request high exactly while entries held
`timescale 1ns/1ps
`include "cwbs_regs.svh"
module cwbs_slice
  import cwbs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       store_strobe,
  input  wire cwbs_addr_t addr_in,
  input  wire cwbs_bptr_t bptr_in,
  input  wire cwbs_acc_t  access_size_code,
  input  wire cwbs_data_t data_in,
  output logic            buffer_full_flag,
  input  wire logic       memory_output_enable,
  input  wire logic       mem_ack,
  output logic            mem_request,
  output cwbs_addr_t      addr_out,
  output cwbs_bptr_t      bptr_out,
  output cwbs_acc_t       acc_out,
  output cwbs_data_t      data_out,
  output logic            out_drive_en
);
  cwbs_cap_if cap ();

  cwbs_capture u_capture (
    .clk              (clk),
    .nrst             (nrst),
    .store_strobe     (store_strobe),
    .addr_in          (addr_in),
    .bptr_in          (bptr_in),
    .access_size_code (access_size_code),
    .data_in          (data_in),
    .cap              (cap)
  );

  function automatic cwbs_ptr_t cwbs_inc(input cwbs_ptr_t p);
    cwbs_inc = p + `CWBS_PTR_ONE;
  endfunction : cwbs_inc

  cwbs_entry_t mem_q [`CWBS_DEPTH];
  cwbs_entry_t mem_d [`CWBS_DEPTH];
  cwbs_ptr_t   wr_q;
  cwbs_ptr_t   wr_d;
  cwbs_ptr_t   rd_q;
  cwbs_ptr_t   rd_d;
  cwbs_cnt_t   cnt_q;
  cwbs_cnt_t   cnt_d;
  logic        full_q;
  logic        full_d;
  logic        req_q;
  logic        req_d;
  logic        oe_q;
  logic        oe_d;
  logic        ack_q;
  logic        ack_d;
  cwbs_entry_t out_q;
  cwbs_entry_t out_d;
  logic        do_push;
  logic        do_pop;

  // ack is taken once per assertion, with or without oe; a held level pops once
  always_comb begin
    oe_d    = memory_output_enable;
    ack_d   = mem_ack;
    do_pop  = mem_ack && !ack_q && (cnt_q != `CWBS_CNT_ZERO);
    // a store into a full buffer is dropped; the processor must stall on the flag
    do_push = cap.push && (cnt_q != `CWBS_CNT_FULL);
    wr_d    = wr_q;
    rd_d    = rd_q;
    cnt_d   = cnt_q;
    for (int i = 0; i < `CWBS_DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (do_push) begin
      mem_d[wr_q] = cap.entry;
      wr_d        = cwbs_inc(wr_q);
    end
    if (do_pop) begin
      rd_d = cwbs_inc(rd_q);
    end
    unique case ({do_push, do_pop})
      2'h2:    cnt_d = cnt_q + `CWBS_CNT_ONE;
      2'h1:    cnt_d = cnt_q - `CWBS_CNT_ONE;
      default: cnt_d = cnt_q;
    endcase
    // a stalling processor reacts one edge late and may already have a store
    // on its way, so the flag keeps room for that store as well
    full_d = (cnt_d >= `CWBS_CNT_LAST) ||
             ((cnt_d == `CWBS_CNT_TWO) && store_strobe);
    req_d  = (cnt_d != `CWBS_CNT_ZERO);
    out_d  = mem_q[rd_d];
    // the slot written at this edge becomes the head: show it at once
    if (do_push && (wr_q == rd_d)) begin
      out_d = cap.entry;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= `CWBS_CNT_ZERO;
      full_q <= 1'b0;
      req_q  <= 1'b0;
      oe_q   <= 1'b0;
      ack_q  <= 1'b0;
      out_q  <= '0;
      for (int i = 0; i < `CWBS_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      cnt_q  <= cnt_d;
      full_q <= full_d;
      req_q  <= req_d;
      oe_q   <= oe_d;
      ack_q  <= ack_d;
      out_q  <= out_d;
      for (int i = 0; i < `CWBS_DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // four slices side by side make the 32-bit address and 36-bit data word
  assign buffer_full_flag = full_q;
  assign mem_request      = req_q;
  assign out_drive_en     = oe_q;
  assign addr_out         = out_q.addr;
  assign bptr_out         = out_q.bptr;
  assign acc_out          = out_q.acc;
  assign data_out         = out_q.data;
endmodule : cwbs_slice

// >>> testbench/cwbs_slice_sva.sv
/* assertions on the ports of one write buffer slice, bound to cwbs_slice.
   assumes one clk domain and a synchronous active-low nrst. */
`timescale 1ns/1ps
module cwbs_slice_sva
  import cwbs_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       store_strobe,
  input wire logic       buffer_full_flag,
  input wire logic       memory_output_enable,
  input wire logic       mem_ack,
  input wire logic       mem_request,
  input wire cwbs_addr_t addr_out,
  input wire cwbs_data_t data_out,
  input wire logic       out_drive_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rst; disable iff (1'b0) !nrst |=> !mem_request && !buffer_full_flag; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_oe; 1 |=> out_drive_en == $past(memory_output_enable); endproperty
  a_oe: assert property (p_oe) else $error("drive enable not following oe");
  property p_req_up; store_strobe && !mem_request |-> ##2 mem_request; endproperty
  a_req_up: assert property (p_req_up) else $error("request late after store");
  property p_req_hold; mem_request && !mem_ack && !$past(mem_ack) |=> mem_request; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped with entries");
  property p_req_fall; $fell(mem_request) |-> $past(mem_ack) || $past(mem_ack, 2); endproperty
  a_req_fall: assert property (p_req_fall) else $error("request fell without ack");
  property p_full_req; buffer_full_flag |-> mem_request; endproperty
  a_full_req: assert property (p_full_req) else $error("full while empty");
  property p_full_why;
    $rose(buffer_full_flag) |-> $past(store_strobe) || $past(store_strobe, 2);
  endproperty
  a_full_why: assert property (p_full_why) else $error("full raised without store");
  property p_oldest;
    mem_request && !mem_ack && !$past(mem_ack) && !$past(mem_ack, 2)
      |=> $stable(addr_out) && $stable(data_out);
  endproperty
  a_oldest: assert property (p_oldest) else $error("head moved without pop");
  c_full: cover property ($rose(buffer_full_flag));
  c_both: cover property (store_strobe && $rose(mem_ack));
  c_empty: cover property ($fell(mem_request));
endmodule : cwbs_slice_sva

bind cwbs_slice cwbs_slice_sva u_sva (.clk, .nrst, .store_strobe, .buffer_full_flag,
  .memory_output_enable, .mem_ack, .mem_request, .addr_out, .data_out, .out_drive_en);

// >>> testbench/cwbs_mem_model.sv
/* memory controller model: drains the slice through oe and ack.
   assumes the bench steers its pace with hold and slow. */
`timescale 1ns/1ps
module cwbs_mem_model
  import cwbs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hold,
  input  wire logic        slow,
  input  wire logic        mem_request,
  input  wire logic        out_drive_en,
  input  wire cwbs_entry_t ent,
  output logic             memory_output_enable,
  output logic             mem_ack,
  output logic             seen,
  output cwbs_entry_t      got,
  output logic             got_en
);
  initial begin
    memory_output_enable = 1'b0;
    mem_ack = 1'b0;
    seen = 1'b0;
    got = '0;
    got_en = 1'b0;
    forever begin
      @(posedge clk);
      if (nrst && mem_request && !hold) begin
        repeat (slow ? 3 : 0) @(posedge clk);
        memory_output_enable <= 1'b1;
        repeat (2) @(posedge clk);
        mem_ack <= 1'b1;
        got <= ent;
        got_en <= out_drive_en;
        seen <= 1'b1;
        @(posedge clk);
        mem_ack <= 1'b0;
        memory_output_enable <= 1'b0;
        seen <= 1'b0;
        // request falls at the edge of the last pop; wait one more edge before looking again
        @(posedge clk);
      end
    end
  end
endmodule : cwbs_mem_model

// >>> testbench/tb_cpu_write_buffer_slice.sv
/* self-checking bench for cwbs_slice with a memory controller model.
   assumes 10 MHz clk and nrst held low for 21 cycles. */
`timescale 1ns/1ps
module tb_cpu_write_buffer_slice
  import cwbs_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        store_strobe = 1'b0;
  logic        hold = 1'b0;
  logic        slow = 1'b0;
  logic        full, req, oe, ack, ode, seen, got_en;
  cwbs_entry_t st_e = '0;
  wire cwbs_entry_t ent;
  cwbs_entry_t got;
  cwbs_entry_t exp_q[$];
  int          miscompares = 0;
  int          samples_checked = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  cwbs_slice dut (.clk(clk), .nrst(nrst), .store_strobe(store_strobe), .addr_in(st_e.addr),
    .bptr_in(st_e.bptr), .access_size_code(st_e.acc), .data_in(st_e.data),
    .buffer_full_flag(full), .memory_output_enable(oe), .mem_ack(ack), .mem_request(req),
    .addr_out(ent.addr), .bptr_out(ent.bptr), .acc_out(ent.acc), .data_out(ent.data),
    .out_drive_en(ode));
  cwbs_mem_model u_mem (.clk(clk), .nrst(nrst), .hold(hold), .slow(slow), .mem_request(req),
    .out_drive_en(ode), .ent(ent), .memory_output_enable(oe), .mem_ack(ack), .seen(seen),
    .got(got), .got_en(got_en));
  task automatic give_verdict();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
    samples_checked++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp_v, seen_v);
    end
  endtask : chk
  // back-to-back stores; a full buffer holds the strobe low instead of losing data
  task automatic store(input int n);
    int w;
    cwbs_entry_t e;
    for (int i = 0; i < n; i++) begin
      w = 0;
      @(posedge clk);
      while (full && w < 60) begin
        store_strobe <= 1'b0;
        @(posedge clk);
        w++;
      end
      if (w >= 60) chk("store_stall", 1, 0);
      if (w >= 60) give_verdict();
      e = cwbs_entry_t'($urandom);
      store_strobe <= 1'b1;
      st_e <= e;
      exp_q.push_back(e);
    end
    @(posedge clk);
    store_strobe <= 1'b0;
  endtask : store
  task automatic drain();
    int w;
    for (w = 0; w < 400 && (req || exp_q.size() != 0); w++) @(posedge clk);
    if (w >= 400) chk("drain_time", 1, 0);
    if (w >= 400) give_verdict();
    repeat (2) @(posedge clk);
    #1 chk("request_empty", req, 0);
  endtask : drain
  always @(posedge clk) begin
    if (seen) begin
      if (exp_q.size() == 0) chk("spare_entry", 1, 0);
      else chk("entry", 32'(got), 32'(exp_q.pop_front()));
      chk("drive_enable", got_en, 1);
    end
  end
  initial begin
    void'($urandom(32'h33DF5FF5));
    repeat (20) @(posedge clk);
    #1 chk("request_reset", req, 0);
    chk("full_reset", full, 0);
    @(posedge clk);
    nrst <= 1'b1;
    hold <= 1'b1;
    store(4);
    repeat (2) @(posedge clk);
    #1 chk("full_at_four", full, 1);
    chk("request_held", req, 1);
    fork
      store(2);
      begin
        repeat (6) @(posedge clk);
        hold <= 1'b0;
      end
    join
    drain();
    store(10);
    slow <= 1'b1;
    store(8);
    drain();
    give_verdict();
  end
endmodule : tb_cpu_write_buffer_slice
